//--- bridge_regs_pkg.sv
package bridge_regs_pkg;

  // ----------------------------------------
  // word offsets in configuration space
  // ----------------------------------------
  localparam logic [7:0] RETRY_OFS  = 8'h78;
  localparam logic [7:0] TMO_OFS    = 8'h80;
  localparam logic [7:0] SLOT_OFS   = 8'hb0;
  localparam logic [7:0] PMCAP_OFS  = 8'hdc;
  localparam logic [7:0] PMCTL_OFS  = 8'he0;
  localparam logic [7:0] THIRD_OFS  = 8'he4;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [31:0] RETRY_RST = 32'h0100_0000;
  localparam logic [15:0] TMO_RST   = 16'h8000;
  localparam logic [4:0]  SLOT_RST  = 5'h00;
  localparam logic [7:0]  CHAS_RST  = 8'h00;

  // ----------------------------------------
  // fixed capability fields
  // ----------------------------------------
  localparam logic [7:0] ID_PM       = 8'h01;
  localparam logic [7:0] ID_SLOT     = 8'h04;
  localparam logic [7:0] ID_HOTSWAP  = 8'h06;
  localparam logic [7:0] PM_NEXT     = 8'h0b;
  localparam logic [7:0] LIST_END    = 8'h00;
  localparam logic [2:0] PM_REV      = 3'b001;
  localparam logic [15:0] PM_FEAT    = {13'h0000, PM_REV};

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ID_LSB   = 0;
  localparam int NEXT_LSB = 8;
  localparam int HI_LSB   = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PS_D0 = 2'b00,
    PS_D3 = 2'b11
  } pstate_t;

  typedef struct packed {
    logic [15:0] down;
    logic [15:0] up;
  } timeouts_t;

  typedef struct packed {
    logic [7:0] chassis;
    logic [1:0] rsvd;
    logic       first;
    logic [4:0] slot;
  } slot_fields_t;

endpackage : bridge_regs_pkg

//--- bridge_timeout_and_capability_regs.sv
`timescale 1ns/1ps
// What this block does
// - retry limit: 32-bit read/write, resets to 0100_0000h
// - upstream master timeout: bits 15:0, read/write, resets to 8000h
// - downstream master timeout: bits 31:16, read/write, resets to 8000h
// - slot slot_cap_identifier reads 04h, read-only
// - slot next pointer reads 00h for the listed strap settings
// - slot number, first-in-chassis, chassis number writable; bits 23:22 zero
// - power slot_cap_identifier reads 01h
// - power capability next pointer reads 0bh
// - power management revision field reads 001
// - wake clock, aux power, init bits and bits 24:22 read zero
// - no D1, no D2, no wake support: bits 31:25 read zero
// - power state field bits 1:0, read/write, resets to D0
// - unimplemented power state write completes, field unchanged
// - D3 to D0 write resets chip, downstream reset stays inactive
// - power control bits 15:2 always read zero
// - third slot_cap_identifier reads 06h
// - third capability next pointer reads 00h, ends list
module bridge_timeout_and_capability_regs #(
  parameter logic [7:0] SLOT_NEXT_OTHER = 8'hdc
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // mode strap pins
  input  wire logic        i_mode_strap_low,
  input  wire logic        i_mode_strap_high,
  // register values to the bridge core
  output logic [31:0]      o_retry_limit,
  output logic [15:0]      o_upstream_timeout,
  output logic [15:0]      o_downstream_timeout,
  output logic [1:0]       o_power_state,
  // reset requests
  output logic             o_chip_reset,
  output logic             o_downstream_reset_n
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // capability pointers address whole dwords; low bits set would be misread by software
  if (SLOT_NEXT_OTHER[1:0] != 2'b00) begin : g_next_align
    $error("SLOT_NEXT_OTHER must be a multiple of 4");
  end

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  // straps are board pins on no clock; only strap_q may feed logic
  logic [1:0] strap_meta_q;
  logic [1:0] strap_q;

  always_ff @(posedge i_clk) begin
    strap_meta_q <= {i_mode_strap_high, i_mode_strap_low};
    strap_q      <= strap_meta_q;
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // every access waits one cycle so readdata can come from a flop
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req;
  logic        acc_wr;
  logic [7:0]  wsel;

  assign req    = i_read | i_write;
  assign acc_wr = i_write & ~wait_q;
  assign wsel   = {i_address[7:2], 2'b00};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // readdata holds until the next read, so a late sampler still sees the answer
  assign o_readdata    = rdata_q;
  assign o_waitrequest = wait_q;

  // ----------------------------------------
  // byte-lane merge
  // ----------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // internal chip reset
  // ----------------------------------------
  // the soft reset clears this bank as well, one cycle after the write
  // the request is registered so it leaves this block free of glitches
  logic soft_q;
  logic clr;

  assign clr = ~i_rst_n | soft_q;

  // ----------------------------------------
  // retry limit and timeouts
  // ----------------------------------------
  logic [31:0]                  retry_q;
  bridge_regs_pkg::timeouts_t   tmo_q;

  always_ff @(posedge i_clk) begin
    if (clr) begin
      retry_q <= bridge_regs_pkg::RETRY_RST;
    end else if (acc_wr && wsel == bridge_regs_pkg::RETRY_OFS) begin
      retry_q <= merge(retry_q, i_writedata, i_byteenable);
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      tmo_q.up   <= bridge_regs_pkg::TMO_RST;
      tmo_q.down <= bridge_regs_pkg::TMO_RST;
    end else if (acc_wr && wsel == bridge_regs_pkg::TMO_OFS) begin
      tmo_q <= merge(tmo_q, i_writedata, i_byteenable);
    end
  end

  assign o_retry_limit        = retry_q;
  assign o_upstream_timeout   = tmo_q.up;
  assign o_downstream_timeout = tmo_q.down;

  // ----------------------------------------
  // slot identification
  // ----------------------------------------
  logic [4:0] slot_q;
  logic       first_q;
  logic [7:0] chas_q;
  logic [31:0] slot_wr;
  logic [7:0]  slot_next;

  assign slot_wr = merge(32'h0000_0000, i_writedata, i_byteenable);

  always_ff @(posedge i_clk) begin
    if (clr) begin
      slot_q  <= bridge_regs_pkg::SLOT_RST;
      first_q <= 1'b0;
    end else if (acc_wr && wsel == bridge_regs_pkg::SLOT_OFS && i_byteenable[2]) begin
      slot_q  <= slot_wr[20:16];
      first_q <= slot_wr[21];
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      chas_q <= bridge_regs_pkg::CHAS_RST;
    end else if (acc_wr && wsel == bridge_regs_pkg::SLOT_OFS && i_byteenable[3]) begin
      chas_q <= slot_wr[31:24];
    end
  end

  // strap_q[0] is the low strap, strap_q[1] the high strap
  assign slot_next = (strap_q[0] || strap_q[1]) ?
                     bridge_regs_pkg::LIST_END : SLOT_NEXT_OTHER;

  // ----------------------------------------
  // power state
  // ----------------------------------------
  bridge_regs_pkg::pstate_t ps_q;
  logic                     ps_wr;
  logic                     ps_ok;

  assign ps_wr = acc_wr && wsel == bridge_regs_pkg::PMCTL_OFS && i_byteenable[0];
  // only D0 and D3 exist; other codes are dropped
  assign ps_ok = i_writedata[1:0] == bridge_regs_pkg::PS_D0 ||
                 i_writedata[1:0] == bridge_regs_pkg::PS_D3;

  always_ff @(posedge i_clk) begin
    if (clr) begin
      ps_q <= bridge_regs_pkg::PS_D0;
    end else if (ps_wr && ps_ok) begin
      case (i_writedata[1:0])
        2'b00: begin
          ps_q <= bridge_regs_pkg::PS_D0;
        end
        2'b11: begin
          ps_q <= bridge_regs_pkg::PS_D3;
        end
        default: begin
          ps_q <= ps_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= ps_wr && ps_q == bridge_regs_pkg::PS_D3 &&
                i_writedata[1:0] == bridge_regs_pkg::PS_D0;
    end
  end

  // the downstream bus reset is not part of the internal chip reset
  logic dsr_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dsr_q <= 1'b1;
    end else begin
      dsr_q <= 1'b1;
    end
  end

  assign o_chip_reset         = soft_q;
  assign o_downstream_reset_n = dsr_q;
  assign o_power_state        = ps_q;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // read-only words are built from constants, so writes cannot reach them
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (wsel)
      bridge_regs_pkg::RETRY_OFS: begin
        rdata_d = retry_q;
      end
      bridge_regs_pkg::TMO_OFS: begin
        rdata_d = tmo_q;
      end
      bridge_regs_pkg::SLOT_OFS: begin
        rdata_d = {chas_q, 2'b00, first_q, slot_q,
                   slot_next, bridge_regs_pkg::ID_SLOT};
      end
      bridge_regs_pkg::PMCAP_OFS: begin
        rdata_d = {bridge_regs_pkg::PM_FEAT, bridge_regs_pkg::PM_NEXT,
                   bridge_regs_pkg::ID_PM};
      end
      bridge_regs_pkg::PMCTL_OFS: begin
        rdata_d = {16'h0000, 14'h0000, ps_q};
      end
      bridge_regs_pkg::THIRD_OFS: begin
        rdata_d = {16'h0000, bridge_regs_pkg::LIST_END,
                   bridge_regs_pkg::ID_HOTSWAP};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // high in the first cycle after a bus reset
  logic reset_seen_q;

  always_ff @(posedge i_clk) begin
    reset_seen_q <= ~i_rst_n;
  end

  sequence s_answer(logic [7:0] ofs);
    i_read && !o_waitrequest && wsel == ofs;
  endsequence

  sequence s_write(logic [7:0] ofs);
    acc_wr && wsel == ofs && i_byteenable == 4'hf;
  endsequence

  sequence s_pulse;
    o_chip_reset ##1 !o_chip_reset;
  endsequence

  retry_reset_val_a: assert property (reset_seen_q |-> o_retry_limit == 32'h0100_0000 &&
    o_upstream_timeout == 16'h8000 && o_downstream_timeout == 16'h8000 && o_power_state == 2'b00)
    else $error("bank reset values wrong");

  retry_write_a: assert property (s_write(8'h78) |=> o_retry_limit == $past(i_writedata))
    else $error("retry limit write lost");

  timeout_write_a: assert property (s_write(8'h80) |=>
    o_upstream_timeout == $past(i_writedata[15:0]) && o_downstream_timeout == $past(i_writedata[31:16]))
    else $error("timeout write lost");

  handshake_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("waitrequest not one-cycle");

  slot_word_a: assert property (s_answer(8'hb0) |-> o_readdata[7:0] == 8'h04 &&
    o_readdata[23:22] == 2'b00) else $error("slot word fixed bits wrong");

  slot_next_a: assert property (s_answer(8'hb0) && (strap_q[0] || strap_q[1]) |->
    o_readdata[15:8] == 8'h00) else $error("slot next pointer not zero");

  pm_cap_word_a: assert property (s_answer(8'hdc) |-> o_readdata == 32'h0001_0b01)
    else $error("power capability word wrong");

  pm_ctl_zero_a: assert property (s_answer(8'he0) |-> o_readdata[31:2] == 30'h0000_0000)
    else $error("power control reserved bits set");

  third_cap_a: assert property (s_answer(8'he4) |-> o_readdata[15:0] == 16'h0006)
    else $error("third capability word wrong");

  bad_state_a: assert property (ps_wr && !ps_ok && !soft_q |=> $stable(o_power_state))
    else $error("unimplemented power state stored");

  wake_reset_a: assert property (ps_wr && o_power_state == 2'b11 && i_writedata[1:0] == 2'b00
    |=> s_pulse) else $error("chip reset pulse missing");

  no_dsr_a: assert property (o_downstream_reset_n)
    else $error("downstream reset asserted");

  chip_reset_clear_a: assert property (o_chip_reset |=> o_retry_limit == 32'h0100_0000 &&
    o_upstream_timeout == 16'h8000 && o_downstream_timeout == 16'h8000 && o_power_state == 2'b00 &&
    slot_q == 5'h00 && !first_q && chas_q == 8'h00) else $error("soft reset left bank values");

  slot_write_a: assert property (s_write(8'hb0) |=>
    {chas_q, first_q, slot_q} == {$past(i_writedata[31:24]), $past(i_writedata[21:16])})
    else $error("slot word write lost");

  ps_store_a: assert property (ps_wr && ps_ok |=>
    o_power_state == $past(i_writedata[1:0]))
    else $error("power state write lost");

  ps_lane_a: assert property (acc_wr && wsel == 8'he0 && !i_byteenable[0] |=>
    $stable(o_power_state))
    else $error("power state written without its lane");

  pm_ctl_state_a: assert property (s_answer(8'he0) |->
    o_readdata[1:0] == $past(o_power_state))
    else $error("power state readback wrong");

  ro_write_a: assert property (acc_wr && (wsel == 8'h7c || wsel == 8'hdc || wsel == 8'he4) |=>
    $stable(o_retry_limit) && $stable(o_upstream_timeout) && $stable(o_downstream_timeout) &&
    $stable(o_power_state)) else $error("read-only write changed a register");

  readdata_hold_a: assert property (!(i_read && o_waitrequest) |=>
    $stable(o_readdata))
    else $error("read data changed without a read");

endmodule : bridge_timeout_and_capability_regs

//--- config_host_model.sv
`timescale 1ns/1ps
module config_host_model (
  // clock and bus answer
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  // bus request
  output logic [7:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  output logic [3:0]       o_byteenable
);
  initial begin
    o_address    = 8'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h0000_0000;
    o_byteenable = 4'h0;
  end

  // ----------------------------------------
  // one avalon access, held until waitrequest is sampled low
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
    @(posedge i_clk);
    o_address    <= a;
    o_writedata  <= d;
    o_byteenable <= be;
    o_read       <= ~wr;
    o_write      <= wr;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) begin
      @(posedge i_clk);
    end
    rd = i_readdata;
    // released address and data lines show the inverse so a stale value cannot pass for a fresh one
    o_read       <= 1'b0;
    o_write      <= 1'b0;
    o_address    <= ~a;
    o_writedata  <= ~d;
  endtask : xfer
endmodule : config_host_model

//--- bridge_timeout_and_capability_regs_tb_top.sv
`timescale 1ns/1ps
module bridge_timeout_and_capability_regs_tb_top;
  localparam logic [7:0] NXT = 8'hdc;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_lo = 1'b1;
  logic        s_hi = 1'b0;
  logic [7:0]  addr;
  logic        rd_q, wr_q, wreq, crst, dsr_n;
  logic [31:0] wdat, rdat, retry;
  logic [3:0]  be;
  logic [15:0] up, down;
  logic [1:0]  ps;
  int          fail_count = 0;
  int          n_compared = 0;
  int          pulses = 0;
  logic [31:0] r;

  always #2 clk = ~clk;

  bridge_timeout_and_capability_regs #(.SLOT_NEXT_OTHER(NXT)) bridge_timeout_and_capability_regs_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd_q), .i_write(wr_q),
    .i_writedata(wdat), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wreq),
    .i_mode_strap_low(s_lo), .i_mode_strap_high(s_hi), .o_retry_limit(retry),
    .o_upstream_timeout(up), .o_downstream_timeout(down), .o_power_state(ps),
    .o_chip_reset(crst), .o_downstream_reset_n(dsr_n));

  config_host_model config_host_model_inst (
    .i_clk(clk), .i_waitrequest(wreq), .i_readdata(rdat), .o_address(addr),
    .o_read(rd_q), .o_write(wr_q), .o_writedata(wdat), .o_byteenable(be));

  // ----------------------------------------
  // reset pulse watch
  // ----------------------------------------
  always @(posedge clk) begin
    if (crst === 1'b1) begin
      pulses++;
    end
    if (rst_n === 1'b1 && dsr_n !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: downstream reset driven", $time);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    config_host_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'hf, r);
    chk(r, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    config_host_model_inst.xfer(1'b1, a, d, b, r);
  endtask : wr

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #40000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h78, 32'h0100_0000);
    rd(8'h80, 32'h8000_8000);
    rd(8'hb0, 32'h0000_0004);
    rd(8'hdc, 32'h0001_0b01);
    rd(8'he0, 32'h0000_0000);
    rd(8'he4, 32'h0000_0006);
    rd(8'h7c, 32'h0000_0000);
    $display("reset values done");
    wr(8'h78, 32'hdead_beef, 4'hf);
    @(posedge clk);
    chk(retry, 32'hdead_beef);
    wr(8'h80, 32'h1234_5678, 4'hf);
    @(posedge clk);
    chk({down, up}, 32'h1234_5678);
    rd(8'h80, 32'h1234_5678);
    wr(8'hb0, 32'hffff_ffff, 4'hf);
    rd(8'hb0, 32'hff3f_0004);
    wr(8'hb0, 32'h0000_0000, 4'b1011);
    rd(8'hb0, 32'h003f_0004);
    wr(8'hdc, 32'hffff_ffff, 4'hf);
    wr(8'he4, 32'hffff_ffff, 4'hf);
    wr(8'h7c, 32'hffff_ffff, 4'hf);
    rd(8'hdc, 32'h0001_0b01);
    rd(8'he4, 32'h0000_0006);
    rd(8'h7c, 32'h0000_0000);
    $display("write access done");
    wr(8'he0, 32'h0000_0000, 4'hf);
    wr(8'he0, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    chk({30'h0, ps}, 32'h0000_0003);
    rd(8'he0, 32'h0000_0003);
    wr(8'he0, 32'h0000_0001, 4'hf);
    rd(8'he0, 32'h0000_0003);
    wr(8'he0, 32'h0000_0002, 4'hf);
    rd(8'he0, 32'h0000_0003);
    chk(pulses, 32'h0000_0000);
    wr(8'he0, 32'h0000_0000, 4'hf);
    repeat (3) @(posedge clk);
    chk(pulses, 32'h0000_0001);
    rd(8'h78, 32'h0100_0000);
    rd(8'h80, 32'h8000_8000);
    rd(8'hb0, 32'h0000_0004);
    rd(8'he0, 32'h0000_0000);
    $display("power state done");
    wr(8'h78, 32'hffff_ffff, 4'b0100);
    rd(8'h78, 32'h01ff_0000);
    wr(8'h80, 32'h0000_0000, 4'b1100);
    rd(8'h80, 32'h0000_8000);
    wr(8'he0, 32'h0000_0003, 4'b1110);
    rd(8'he0, 32'h0000_0000);
    $display("byte lanes done");
    for (int i = 0; i < 4; i++) begin
      s_lo <= i[1];
      s_hi <= i[0];
      repeat (3) @(posedge clk);
      rd(8'hb0, {16'h0000, (i == 0) ? NXT : 8'h00, 8'h04});
    end
    $display("strap pointer done");
    end_of_test();
  end
endmodule : bridge_timeout_and_capability_regs_tb_top
